/* sps_pkg.sv */
/*
 * sps_pkg: register indices, field positions, reset values and timing
 * constants of the SPI port control and status block.
 * Assumes a 20 MHz system clock and 32-bit AHB-Lite register access.
 */
package sps_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_CFG = 16'hC0C8;
    localparam logic [15:0] IDX_CTL = 16'hC0CA;
    localparam logic [15:0] IDX_IEN = 16'hC0CC;
    localparam logic [15:0] IDX_STA = 16'hC0CE;
    localparam logic [15:0] IDX_CLR = 16'hC0D0;
    localparam logic [15:0] IDX_CRC = 16'hC0D2;
    localparam logic [15:0] IDX_DAT = 16'hC0D6;
    // configuration fields
    localparam int CFG_ACT  = 7;
    localparam int CFG_MSTR = 6;
    localparam int CFG_SSEN = 5;
    localparam int DLY_MSB  = 4;
    localparam logic [15:0] CFG_RST   = 16'h8000;
    localparam logic [15:0] CFG_WMASK = 16'hFE7F;
    // control fields
    localparam int CTL_FINIT = 14;
    localparam int CTL_BYTE  = 13;
    localparam int CTL_FDX   = 12;
    localparam int CTL_SSMAN = 11;
    localparam int CTL_RDEN  = 10;
    localparam int TXL_LSB   = 3;
    localparam int RXL_LSB   = 0;
    // interrupt enable, status and clear fields
    localparam int STA_ERR = 7;
    localparam int IRQ_RX  = 2;
    localparam int IRQ_TX  = 1;
    localparam int IRQ_BLK = 0;
    // crc control fields
    localparam int CRC_ONE = 10;
    localparam logic [15:0] CRC_WMASK = 16'hE800;
    // fifo and shift sizes
    localparam int PTR_W = 3;
    localparam logic [PTR_W:0] FIFO_DEPTH = 4'h8;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // half bit time of the master clock
    localparam int CLK_HZ = 20_000_000;
    localparam int HALF_BIT_NS = 200;
    localparam int HALF_CYC = (HALF_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    // master engine states
    typedef enum logic [2:0] {M_IDLE, M_LEAD, M_SHIFT, M_TRAIL, M_GAP} sps_mst_t;
endpackage : sps_pkg

/* sps_port.sv */
/*
 * sps_port: register slave and byte engine of the SPI port, master or
 * slave, with eight byte transmit and receive fifos and status flags.
 * Assumes AHB-Lite single word transfers, a 20 MHz clock, SPI mode 0,
 * msb first; a block dma engine elsewhere pulses blk_done.
 */
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sps_port
    import sps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        blk_done,
    output var  logic        irq,
    input  wire logic        sck_in,
    output var  logic        sck_out,
    output var  logic        sck_oe,
    input  wire logic        ss_b_in,
    output var  logic        ss_b_out,
    output var  logic        ss_b_oe,
    input  wire logic        mosi_in,
    output var  logic        mosi_out,
    output var  logic        mosi_oe,
    input  wire logic        miso_in,
    output var  logic        miso_out,
    output var  logic        miso_oe
);
    logic [15:0] cfg;
    logic        byte_mode, full_dx, ss_manual, read_en;
    logic [2:0]  tx_len, rx_len, ien;
    logic        rx_flag, tx_flag, blk_flag, fifo_err;
    logic [15:0] crc_q;
    logic        dp_we;
    logic [15:0] dp_idx;
    logic [7:0]  tx_mem [0:7];
    logic [7:0]  rx_mem [0:7];
    logic [PTR_W:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [3:0]  s1, s2, s3;
    sps_mst_t    st;
    logic [7:0]  hcnt;
    logic [5:0]  dcnt;
    logic [2:0]  bcnt;
    logic [7:0]  sh_tx, sh_rx;
    logic        rd_xfer, loaded;

    // address phase decode
    logic        a_ok, a_take, rd_req;
    logic [15:0] a_idx;
    assign a_ok   = haddr[31:18] == 14'h0000;
    assign a_idx  = a_ok ? haddr[17:2] : 16'h0000;
    assign a_take = hsel && htrans[1] && hready;
    assign rd_req = a_take && !hwrite;

    // data phase write strobes
    logic w_cfg, w_ctl, w_ien, w_clr, w_crc, w_dat, finit;
    assign w_cfg = dp_we && dp_idx == IDX_CFG;
    assign w_ctl = dp_we && dp_idx == IDX_CTL;
    assign w_ien = dp_we && dp_idx == IDX_IEN;
    assign w_clr = dp_we && dp_idx == IDX_CLR;
    assign w_crc = dp_we && dp_idx == IDX_CRC;
    assign w_dat = dp_we && dp_idx == IDX_DAT;
    assign finit = w_ctl && hwdata[CTL_FINIT];

    // fifo levels
    logic [PTR_W:0] tx_cnt, rx_cnt;
    logic tx_full, tx_empty, rx_full, rx_empty;
    assign tx_cnt   = tx_wp - tx_rp;
    assign rx_cnt   = rx_wp - rx_rp;
    assign tx_full  = tx_cnt == FIFO_DEPTH;
    assign tx_empty = tx_cnt == '0;
    assign rx_full  = rx_cnt == FIFO_DEPTH;
    assign rx_empty = rx_cnt == '0;

    // synchronised pins: sck, ss, mosi, miso
    logic sck_s, ss_s, mosi_s, miso_s, sck_p;
    assign sck_s  = s2[0];
    assign ss_s   = s2[1];
    assign mosi_s = s2[2];
    assign miso_s = s2[3];
    assign sck_p  = s3[0];

    // mode and length decode
    logic       mst_en, m_rd;
    logic [4:0] dly;
    logic [3:0] nb;
    assign mst_en = cfg[CFG_MSTR];
    assign dly    = cfg[DLY_MSB:0];
    assign m_rd   = mst_en ? (st == M_IDLE ? read_en : rd_xfer) : read_en;
    assign nb     = (m_rd ? rx_len : tx_len) == 3'h0 ? BYTE_BITS
                  : {1'b0, m_rd ? rx_len : tx_len};

    // engine events
    logic m_tick, m_start, m_last, s_sel, s_load, s_rise, s_fall, s_last;
    logic done, cap, eng_pop, eng_push, under, tx_evt, rd_pop;
    logic [7:0] push_d;
    assign m_tick  = st != M_IDLE && hcnt == HALF_LAST;
    assign m_start = mst_en && st == M_IDLE && (read_en || !tx_empty);
    assign m_last  = st == M_SHIFT && m_tick && sck_out && bcnt == 3'(nb - 4'h1);
    assign s_sel   = !mst_en && !ss_s;
    assign s_load  = s_sel && !loaded;
    assign s_rise  = s_sel && loaded && sck_s && !sck_p;
    assign s_fall  = s_sel && loaded && !sck_s && sck_p;
    assign s_last  = s_rise && bcnt == 3'(nb - 4'h1);
    assign done    = m_last || s_last;
    assign cap     = m_rd || full_dx;
    assign eng_pop = (m_start && !read_en) || (s_load && !read_en && !tx_empty);
    assign under   = s_load && !read_en && tx_empty;
    assign eng_push = done && cap && !rx_full;
    assign tx_evt  = done && !m_rd;
    assign push_d  = mst_en ? sh_rx : {sh_rx[6:0], mosi_s};
    assign rd_pop  = rd_req && a_idx == IDX_DAT && !rx_empty;

    // read value of the addressed register
    logic [15:0] rd_val;
    always_comb begin
        unique case (a_idx)
            IDX_CFG: rd_val = {cfg[15:8], st != M_IDLE, cfg[6:0]};
            IDX_CTL: rd_val = {2'b00, byte_mode, full_dx, ss_manual, read_en,
                               !tx_full, !rx_empty, tx_empty, rx_full,
                               tx_len, rx_len};
            IDX_IEN: rd_val = {13'h0000, ien};
            IDX_STA: rd_val = {8'h00, fifo_err, 4'h0, rx_flag, tx_flag, blk_flag};
            IDX_CRC: rd_val = crc_q | (16'h0001 << CRC_ONE);
            IDX_DAT: rd_val = rx_empty ? 16'h0000 : {8'h00, rx_mem[rx_rp[PTR_W-1:0]]};
            default: rd_val = 16'h0000;
        endcase
    end

    // bus slave: zero wait state, read data registered at the address phase
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dp_we     <= 1'b0;
            dp_idx    <= 16'h0000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            if (hready) begin
                dp_we  <= a_take && hwrite;
                dp_idx <= a_idx;
            end
            if (rd_req) begin
                hrdata <= {16'h0000, rd_val};
            end
        end
    end

    // configuration, control, enable and crc registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg <= CFG_RST;
            {byte_mode, full_dx, ss_manual} <= 3'h0;
            tx_len <= 3'h0;
            rx_len <= 3'h0;
            ien    <= 3'h0;
            crc_q  <= 16'h0000;
        end else begin
            if (w_cfg) begin
                cfg <= hwdata[15:0] & CFG_WMASK;
                if (st != M_IDLE) begin
                    cfg[CFG_MSTR] <= cfg[CFG_MSTR];
                end
            end
            if (w_ctl) begin
                byte_mode <= hwdata[CTL_BYTE];
                full_dx   <= hwdata[CTL_FDX] && !cfg[15];
                ss_manual <= hwdata[CTL_SSMAN];
                tx_len    <= hwdata[TXL_LSB+2:TXL_LSB];
                rx_len    <= hwdata[RXL_LSB+2:RXL_LSB];
            end
            if (w_ien) begin
                ien <= hwdata[IRQ_RX:IRQ_BLK];
            end
            if (w_crc) begin
                crc_q <= hwdata[15:0] & CRC_WMASK;
            end
        end
    end

    // read enable: software sets, master start clears, a write wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            read_en <= 1'b0;
        end else if (w_ctl) begin
            read_en <= hwdata[CTL_RDEN];
        end else if (m_start) begin
            read_en <= 1'b0;
        end
    end

    // transmit fifo: filled by data writes in byte mode, drained by engine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_wp <= '0;
            tx_rp <= '0;
        end else if (finit) begin
            tx_wp <= '0;
            tx_rp <= '0;
        end else begin
            if (w_dat && byte_mode && !tx_full) begin
                tx_mem[tx_wp[PTR_W-1:0]] <= hwdata[7:0];
                tx_wp <= tx_wp + 4'h1;
            end
            if (eng_pop) begin
                tx_rp <= tx_rp + 4'h1;
            end
        end
    end

    // receive fifo: filled by engine, drained by data reads
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_wp <= '0;
            rx_rp <= '0;
        end else if (finit) begin
            rx_wp <= '0;
            rx_rp <= '0;
        end else begin
            if (eng_push) begin
                rx_mem[rx_wp[PTR_W-1:0]] <= push_d;
                rx_wp <= rx_wp + 4'h1;
            end
            if (rd_pop) begin
                rx_rp <= rx_rp + 4'h1;
            end
        end
    end

    // fifo error: underflow or overflow, cleared only by fifo init
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fifo_err <= 1'b0;
        end else if (finit) begin
            fifo_err <= 1'b0;
        end else if (under || (done && cap && rx_full)) begin
            fifo_err <= 1'b1;
        end
    end

    // interrupt flags: tx and blk sticky, rx cleared by reading the last byte; a set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {rx_flag, tx_flag, blk_flag} <= 3'h0;
        end else begin
            if (eng_push && byte_mode) begin
                rx_flag <= 1'b1;
            end else if (rd_pop && rx_cnt == 4'h1) begin
                rx_flag <= 1'b0;
            end
            if (tx_evt && byte_mode) begin
                tx_flag <= 1'b1;
            end else if (w_clr && hwdata[IRQ_TX]) begin
                tx_flag <= 1'b0;
            end
            if (blk_done && !byte_mode) begin
                blk_flag <= 1'b1;
            end else if (w_clr && hwdata[IRQ_BLK]) begin
                blk_flag <= 1'b0;
            end
        end
    end

    // interrupt request gated by the enables
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |({rx_flag, tx_flag, blk_flag} & ien);
        end
    end

    // two flip-flop synchronisers for the pins, plus an edge stage
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    // sck rests low in mode 0, the other pins rest high
                    s1[gi] <= (gi != 0);
                    s2[gi] <= (gi != 0);
                    s3[gi] <= (gi != 0);
                end else begin
                    s1[gi] <= gi == 0 ? sck_in : gi == 1 ? ss_b_in
                            : gi == 2 ? mosi_in : miso_in;
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                end
            end
        end
    endgenerate

    // master sequencer: lead delay, shift, trail delay, select high gap
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st   <= M_IDLE;
            hcnt <= 8'h00;
            dcnt <= 6'h00;
        end else begin
            hcnt <= (st == M_IDLE || m_tick) ? 8'h00 : hcnt + 8'h01;
            unique case (st)
                M_IDLE: if (m_start) begin
                    st   <= M_LEAD;
                    dcnt <= 6'h00;
                end
                M_LEAD, M_TRAIL, M_GAP: begin
                    if (dcnt >= {1'b0, dly}) begin
                        st   <= st == M_LEAD ? M_SHIFT : st == M_TRAIL ? M_GAP : M_IDLE;
                        dcnt <= 6'h00;
                    end else if (m_tick) begin
                        dcnt <= dcnt + 6'h01;
                    end
                end
                M_SHIFT: if (m_last) begin
                    st <= M_TRAIL;
                end
            endcase
        end
    end

    // shift datapath shared by master and slave
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sh_tx <= 8'h00;
            sh_rx <= 8'h00;
            bcnt  <= 3'h0;
            rd_xfer <= 1'b0;
            loaded  <= 1'b0;
            sck_out  <= 1'b0;
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
        end else if (m_start || s_load) begin
            rd_xfer <= read_en;
            loaded  <= s_load;
            bcnt    <= 3'h0;
            sh_rx   <= 8'h00;
            sh_tx   <= eng_pop ? tx_mem[tx_rp[PTR_W-1:0]] << (BYTE_BITS - nb) : 8'h00;
            mosi_out <= eng_pop && mst_en && tx_mem[tx_rp[PTR_W-1:0]][3'(nb - 4'h1)];
            miso_out <= eng_pop && !mst_en && tx_mem[tx_rp[PTR_W-1:0]][3'(nb - 4'h1)];
        end else if (st == M_SHIFT && m_tick) begin
            sck_out <= !sck_out;
            if (!sck_out) begin
                sh_rx <= {sh_rx[6:0], miso_s};
            end else if (!m_last) begin
                bcnt     <= bcnt + 3'h1;
                sh_tx    <= sh_tx << 1;
                mosi_out <= sh_tx[6];
            end
        end else if (s_rise) begin
            sh_rx <= {sh_rx[6:0], mosi_s};
            bcnt  <= bcnt + 3'h1;
            if (s_last) begin
                loaded <= 1'b0;
            end
        end else if (s_fall) begin
            sh_tx    <= sh_tx << 1;
            miso_out <= sh_tx[6];
        end else if (!s_sel && !mst_en) begin
            loaded <= 1'b0;
        end
    end

    // pin drivers: select level and output enables
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ss_b_out <= 1'b1;
            {sck_oe, ss_b_oe, mosi_oe, miso_oe} <= 4'h0;
        end else begin
            if (dly == 5'h00) begin
                ss_b_out <= !ss_manual;
            end else begin
                ss_b_out <= !(st == M_LEAD || st == M_SHIFT || st == M_TRAIL);
            end
            sck_oe  <= mst_en;
            mosi_oe <= mst_en;
            ss_b_oe <= mst_en && cfg[CFG_SSEN];
            miso_oe <= s_sel;
        end
    end

    // sck rises counted apart from the bit counter, for the length check
    logic [3:0] rise_seen;
    always_ff @(posedge clk) begin
        if (!rst_b || st == M_IDLE) begin
            rise_seen <= 4'h0;
        end else if (st == M_SHIFT && m_tick && !sck_out) begin
            rise_seen <= rise_seen + 4'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence rd_start_s;
        m_start && read_en && !w_ctl;
    endsequence
    sequence clr_tx_s;
        w_clr && hwdata[IRQ_TX] && !(tx_evt && byte_mode);
    endsequence

    ss_manual_a: assert property (mst_en && dly == 5'h00 |=> ss_b_out == !$past(ss_manual))
        else $error("manual select level wrong");
    rd_clear_a: assert property (rd_start_s |=> !read_en && rd_xfer)
        else $error("read enable not cleared at start");
    fifo_bits_a: assert property (rd_req && a_idx == IDX_CTL |=>
        hrdata[9] == !$past(tx_full) && hrdata[7] == $past(tx_empty))
        else $error("control status bits wrong");
    rx_bits_a: assert property (rd_req && a_idx == IDX_CTL |=>
        hrdata[8] == !$past(rx_empty) && hrdata[6] == $past(rx_full))
        else $error("receive status bits wrong");
    bit_count_a: assert property (m_last |-> rise_seen == nb)
        else $error("master bit count wrong");
    irq_gate_a: assert property (irq |-> $past(|({rx_flag, tx_flag, blk_flag} & ien)))
        else $error("interrupt without enabled flag");
    err_clear_a: assert property (finit |=> !fifo_err && tx_empty && rx_empty)
        else $error("fifo init did not clear");
    tx_clear_a: assert property (clr_tx_s |=> !tx_flag ##1 !irq || tx_flag)
        else $error("transmit flag not cleared");
    rx_flag_a: assert property (eng_push && byte_mode |=> rx_flag)
        else $error("receive flag not set");
    sta_quiet_a: assert property (rd_req && a_idx == IDX_STA |=> $stable(rx_rp))
        else $error("status read changed state");
endmodule : sps_port
`default_nettype wire

/* sps_peer.sv */
/* sps_peer: behavioural spi peripheral standing on the far side of the port.
   assumes mode 0, msb first, active low select, a 2-flop synchronised master. */
`timescale 1ns/1ps
`default_nettype none
module sps_peer (
    input  wire logic       sck,
    input  wire logic       ss_b,
    input  wire logic       mosi,
    output var  logic       miso,
    output var  logic [7:0] got
);
    logic [7:0] tx_sh = 8'hC3;

    // collect master data at sck rise while selected
    always @(posedge sck) begin
        if (!ss_b) begin
            got <= {got[6:0], mosi};
        end
    end

    // reload the answer pattern on deselect, advance it at sck fall
    always @(posedge ss_b, negedge sck) begin
        if (ss_b) begin
            tx_sh <= 8'hC3;
        end else begin
            tx_sh <= {tx_sh[6:0], tx_sh[7]};
        end
    end

    // a released line shows the inverse of the reloaded pattern msb, never a held value
    assign miso = ss_b ? ~tx_sh[7] : tx_sh[7];
endmodule : sps_peer
`default_nettype wire

/* sps_port_tb.sv */
/* sps_port_tb: register-level test of the spi port control and status block.
   assumes the sps_peer model on the link and one ahb-lite master here. */
`timescale 1ns/1ps
`default_nettype none
module sps_port_tb
    import sps_pkg::*;
;
    logic        clk, rst_b, hsel, hwrite, blk_done, sck_q, slv_ss_b;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic        hreadyout, hresp, irq, sck_out, sck_oe, ss_b_out, ss_b_oe;
    logic        mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
    logic [7:0]  got;
    int          mismatches, checks_done, rises, base, cycles, n;
    wire logic   sck_w, ss_w, mosi_w, miso_w;

    // resolve each pin from whoever drives it; sck pulls low, select follows the bench
    assign sck_w  = sck_oe ? sck_out : 1'b0;
    assign ss_w   = ss_b_oe ? ss_b_out : slv_ss_b;
    assign mosi_w = mosi_oe ? mosi_out : ~mosi_out;
    assign miso_w = miso_oe ? miso_out : peer_miso;

    sps_port sps_port_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .blk_done(blk_done),
        .irq(irq), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .ss_b_in(ss_w),
        .ss_b_out(ss_b_out), .ss_b_oe(ss_b_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe)
    );
    sps_peer sps_peer_inst (.sck(sck_w), .ss_b(ss_w), .mosi(mosi_w), .miso(peer_miso), .got(got));

    // clock of 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // count sck rises and cut a hung run short
    always @(posedge clk) begin
        sck_q <= sck_out;
        if (sck_out === 1'b1 && sck_q === 1'b0)
            rises <= rises + 1;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            $display("[ERR] %0t timeout", $time);
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one single ahb-lite transfer; waits on hready in both phases
    task automatic bus(input logic [15:0] idx, input logic wr_en, input logic [15:0] wd,
                       output logic [15:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr_en;
        haddr  <= {14'h0000, idx, 2'h0};
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
        end
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
        end
        rd = hrdata[15:0];
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
        logic [15:0] dummy;
        bus(idx, 1'b1, wd, dummy);
    endtask : wr

    task automatic rc(input logic [15:0] idx, input logic [15:0] exp);
        logic [15:0] r;
        bus(idx, 1'b0, 16'h0000, r);
        chk(r, exp);
    endtask : rc

    // poll one register bit until it reaches the wanted level
    task automatic wait_bit(input logic [15:0] idx, input int b, input logic val);
        logic [15:0] r;
        bus(idx, 1'b0, 16'h0000, r);
        while (r[b] !== val) begin
            bus(idx, 1'b0, 16'h0000, r);
        end
    endtask : wait_bit

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        blk_done = 1'b0;
        slv_ss_b = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rc(IDX_IEN, 16'h0000);
        rc(IDX_STA, 16'h0000);
        rc(IDX_CTL, 16'h0280);
        rc(16'hC0E0, 16'h0000);
        // master, manual select; reserved bits written as zero
        wr(IDX_CFG, 16'h0060);
        wr(IDX_CTL, 16'h0800);
        repeat (3) @(posedge clk);
        chk({14'h0000, ss_b_oe, ss_b_out}, 16'h0002);
        wr(IDX_CTL, 16'h0000);
        repeat (3) @(posedge clk);
        chk({15'h0000, ss_b_out}, 16'h0001);
        // every bit length: one write frame, then one read frame
        for (int l = 0; l < 8; l++) begin
            n = (l == 0) ? 8 : l;
            wr(IDX_IEN, 16'h0002);
            wr(IDX_CTL, 16'h2800 | 16'(l << 3));
            base = rises;
            wr(IDX_DAT, 16'h00A5);
            wait_bit(IDX_STA, IRQ_TX, 1'b1);
            chk(16'(rises - base), 16'(n));
            chk({8'h00, got & 8'((1 << n) - 1)}, {8'h00, 8'hA5 & 8'((1 << n) - 1)});
            chk({15'h0000, irq}, 16'h0001);
            wr(IDX_CLR, 16'h0000);
            rc(IDX_STA, 16'h0002);
            wr(IDX_CLR, 16'h0002);
            rc(IDX_STA, 16'h0000);
            chk({15'h0000, irq}, 16'h0000);
            wr(IDX_CTL, 16'h2000);
            wr(IDX_IEN, 16'h0004);
            wr(IDX_CTL, 16'h2C00 | 16'(l));
            wait_bit(IDX_STA, IRQ_RX, 1'b1);
            rc(IDX_CTL, 16'h2B80 | 16'(l));
            chk({15'h0000, irq}, 16'h0001);
            wr(IDX_IEN, 16'h0000);
            repeat (2) @(posedge clk);
            chk({15'h0000, irq}, 16'h0000);
            rc(IDX_DAT, 16'(8'hC3 >> (8 - n)));
            rc(IDX_STA, 16'h0000);
            wr(IDX_CTL, 16'h2000);
        end
        // fill the receive fifo, then overflow it once
        for (int i = 0; i < 9; i++) begin
            wr(IDX_CTL, 16'h2C00);
            wait_bit(IDX_CTL, CTL_RDEN, 1'b0);
            wait_bit(IDX_CFG, CFG_ACT, 1'b0);
        end
        rc(IDX_CTL, 16'h2BC0);
        rc(IDX_STA, 16'h0084);
        // every stored byte is the peer pattern; the ninth was dropped
        for (int i = 0; i < 8; i++)
            rc(IDX_DAT, 16'h00C3);
        rc(IDX_CTL, 16'h2A80);
        rc(IDX_STA, 16'h0080);
        wr(IDX_CTL, 16'h6000);
        rc(IDX_CTL, 16'h2280);
        wait_bit(IDX_STA, STA_ERR, 1'b0);
        rc(IDX_STA, 16'h0000);
        // slave mode: fill the transmit fifo with eight bytes until it reads full
        wr(IDX_CFG, 16'h0000);
        wr(IDX_CTL, 16'h2000);
        for (int i = 0; i < 8; i++)
            wr(IDX_DAT, 16'(i));
        rc(IDX_CTL, 16'h2000);
        wr(IDX_CTL, 16'h6000);
        rc(IDX_CTL, 16'h2280);
        // selected as slave with nothing to send: transmit underflow
        slv_ss_b <= 1'b0;
        repeat (6) @(posedge clk);
        rc(IDX_STA, 16'h0080);
        rc(IDX_CTL, 16'h2280);
        slv_ss_b <= 1'b1;
        wr(IDX_CTL, 16'h6000);
        // a block completion in byte mode sets no flag
        blk_done <= 1'b1;
        @(posedge clk);
        blk_done <= 1'b0;
        repeat (2) @(posedge clk);
        rc(IDX_STA, 16'h0000);
        // block mode completion flag, its enable and its clear
        wr(IDX_CTL, 16'h0000);
        blk_done <= 1'b1;
        @(posedge clk);
        blk_done <= 1'b0;
        @(posedge clk);
        rc(IDX_STA, 16'h0001);
        chk({15'h0000, irq}, 16'h0000);
        wr(IDX_IEN, 16'h0001);
        rc(IDX_IEN, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr(IDX_STA, 16'h0000);
        rc(IDX_STA, 16'h0001);
        wr(IDX_CLR, 16'h0000);
        rc(IDX_STA, 16'h0001);
        wr(IDX_CLR, 16'h0001);
        rc(IDX_STA, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        conclude();
    end
endmodule : sps_port_tb
`default_nettype wire
